// File: shared/bch_regs.vh
// register offsets, fields and reset values of the bridge header tail
`ifndef BCH_REGS_VH
`define BCH_REGS_VH

// configuration byte offsets, dword aligned where a dword is decoded
`define BCH_OFF_IO_HIGH      8'h30
`define BCH_OFF_CAP_PTR      8'h34
`define BCH_OFF_ROM_BASE     8'h38
`define BCH_OFF_IRQ_DWORD    8'h3c
`define BCH_OFF_IRQ_LINE     8'h3c
`define BCH_OFF_IRQ_PIN      8'h3d
`define BCH_OFF_BRIDGE_CTRL  8'h3e

// lowest legal start of the capability list
`define BCH_CAP_SPACE_BASE   8'h40

// reset and fixed read-back values
`define BCH_CAP_PTR_VAL      8'h50
`define BCH_IRQ_LINE_VAL     8'h00
`define BCH_IRQ_PIN_RST      8'h01
`define BCH_BRIDGE_CONTROL_EXT_RSVD_VAL   4'h0
`define BCH_BRIDGE_CONTROL_EXT_DT_VAL     3'h0

// bridge control field positions
`define BCH_BRIDGE_CONTROL_EXT_RSVD_MSB   15
`define BCH_BRIDGE_CONTROL_EXT_RSVD_LSB   12
`define BCH_BRIDGE_CONTROL_EXT_DTE_BIT    11
`define BCH_BRIDGE_CONTROL_EXT_DTS_BIT    10
`define BCH_BRIDGE_CONTROL_EXT_SDT_BIT    9
`define BCH_BRIDGE_CONTROL_EXT_LOW_MSB    8

// interrupt pin selector codes
`define BCH_PIN_INTA         8'h01
`define BCH_PIN_INTB         8'h02
`define BCH_PIN_INTC         8'h03
`define BCH_PIN_INTD         8'h04

// byte lanes of the interrupt dword
`define BCH_BE_PIN_LANE      1

`endif

// File: logic/bch_intx_msg.v
// sends assert and deassert interrupt messages over the hub link
`timescale 1ns/10ps
`include "bch_regs.vh"

module bch_intx_msg (
    input  wire       clk_in,        // host clock
    input  wire       reset_in,      // sync reset, active high
    input  wire [7:0] pin_code_in,   // interrupt pin selector value
    input  wire       irq_level_in,  // port interrupt request level
    input  wire       ready_in,      // hub link takes message
    output reg        valid_out,     // message pending
    output reg        assert_out,    // 1 assert, 0 deassert
    output reg  [1:0] intx_out       // 0 a, 1 b, 2 c, 3 d
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg       state_q;
    reg       state_d;
    reg       sent_q;
    reg       sent_d;
    reg       valid_d;
    reg       assert_d;
    reg [1:0] intx_d;
    reg       code_ok;
    reg [1:0] code_intx;

    // decode selector, reserved codes raise nothing
    always @* begin
        code_ok   = 1'b1;
        code_intx = 2'h0;
        case (pin_code_in)
            `BCH_PIN_INTA: code_intx = 2'h0;
            `BCH_PIN_INTB: code_intx = 2'h1;
            `BCH_PIN_INTC: code_intx = 2'h2;
            `BCH_PIN_INTD: code_intx = 2'h3;
            default:       code_ok   = 1'b0;
        endcase
    end

    always @* begin
        state_d  = state_q;
        sent_d   = sent_q;
        valid_d  = valid_out;
        assert_d = assert_out;
        intx_d   = intx_out;
        case (state_q)
            ST_IDLE: begin
                // deassert reuses the line that was asserted
                if (irq_level_in && !sent_q && code_ok) begin
                    valid_d  = 1'b1;
                    assert_d = 1'b1;
                    intx_d   = code_intx;
                    state_d  = ST_SEND;
                end else if (!irq_level_in && sent_q) begin
                    valid_d  = 1'b1;
                    assert_d = 1'b0;
                    state_d  = ST_SEND;
                end
            end
            ST_SEND: begin
                if (ready_in) begin
                    valid_d = 1'b0;
                    sent_d  = assert_out;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                valid_d = 1'b0;
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            state_q    <= ST_IDLE;
            sent_q     <= 1'b0;
            valid_out  <= 1'b0;
            assert_out <= 1'b0;
            intx_out   <= 2'h0;
        end else begin
            state_q    <= state_d;
            sent_q     <= sent_d;
            valid_out  <= valid_d;
            assert_out <= assert_d;
            intx_out   <= intx_d;
        end
    end

endmodule // bch_intx_msg

// File: logic/bch_config_tail.v
// tail of the bridge type-1 configuration header with interrupt emulation
//
// Function
// - no upper I/O base/limit words, no decode
// - no expansion ROM base register
// - capability pointer reads fixed 50h, read-only
// - capability list starts at or above 40h
// - interrupt line reads 00h, read-only
// - pin codes 1..4 select INTA..INTD
// - pin selector resets 01h, one write
// - interrupt sent as hub link message
// - bridge control 15:12 read zero
// - bridge control bits 11:9 hardwired zero
`timescale 1ns/10ps
`include "bch_regs.vh"

module bch_config_tail (
    input  wire        clk_in,          // host clock, 10 MHz
    input  wire        reset_in,        // sync reset, active high
    input  wire        cfg_valid_in,    // config cycle request
    input  wire        cfg_write_in,    // 1 write, 0 read
    input  wire [7:0]  cfg_addr_in,     // byte offset, bits 1:0 ignored
    input  wire [3:0]  cfg_be_in,       // byte enables of the dword
    input  wire [31:0] cfg_wdata_in,    // write data
    input  wire [8:0]  bridge_control_ext_low_in,    // bridge control bits 8:0
    input  wire        irq_level_in,    // port interrupt request
    input  wire        msg_ready_in,    // hub link takes message
    output reg         cfg_ack_out,     // config cycle done
    output reg  [31:0] cfg_rdata_out,   // read data
    output reg         pin_locked_out,  // pin selector written
    output wire        msg_valid_out,   // message pending
    output wire        msg_assert_out,  // 1 assert, 0 deassert
    output wire [1:0]  msg_intx_out     // selected legacy line
);

    reg  [7:0]  pin_q;
    reg  [7:0]  pin_d;
    reg         locked_d;
    reg  [31:0] rdata_d;
    reg  [15:0] bridge_control_ext_rd;
    wire [7:0]  dw_addr;
    wire        hit_io_high;
    wire        hit_cap;
    wire        hit_rom;
    wire        hit_irq;
    wire        pin_wr;
    wire [7:0]  cap_ptr;

    assign dw_addr = {cfg_addr_in[7:2], 2'b00};

    // upper I/O words and ROM base decode only to read zero
    assign hit_io_high = (dw_addr == `BCH_OFF_IO_HIGH);
    assign hit_rom     = (dw_addr == `BCH_OFF_ROM_BASE);
    assign hit_cap     = (dw_addr == `BCH_OFF_CAP_PTR);
    assign hit_irq     = (dw_addr == `BCH_OFF_IRQ_DWORD);

    // pointer never points below the capability space
    assign cap_ptr = (`BCH_CAP_PTR_VAL < `BCH_CAP_SPACE_BASE) ?
                     `BCH_CAP_SPACE_BASE : `BCH_CAP_PTR_VAL;

    // only the byte lane of the pin selector is writable
    assign pin_wr = cfg_valid_in && cfg_write_in && hit_irq &&
                    cfg_be_in[`BCH_BE_PIN_LANE];

    // write-once pin selector
    always @* begin
        pin_d    = pin_q;
        locked_d = pin_locked_out;
        if (pin_wr && !pin_locked_out) begin
            pin_d    = cfg_wdata_in[15:8];
            locked_d = 1'b1;
        end
    end

    // bridge control image: hardwired upper bits, live lower bits
    always @* begin
        bridge_control_ext_rd = 16'h0000;
        bridge_control_ext_rd[`BCH_BRIDGE_CONTROL_EXT_RSVD_MSB:`BCH_BRIDGE_CONTROL_EXT_RSVD_LSB] =
            `BCH_BRIDGE_CONTROL_EXT_RSVD_VAL;
        bridge_control_ext_rd[`BCH_BRIDGE_CONTROL_EXT_DTE_BIT:`BCH_BRIDGE_CONTROL_EXT_SDT_BIT] =
            `BCH_BRIDGE_CONTROL_EXT_DT_VAL;
        bridge_control_ext_rd[`BCH_BRIDGE_CONTROL_EXT_LOW_MSB:0] = bridge_control_ext_low_in;
    end

    // read mux, unmapped and unimplemented dwords return zero
    always @* begin
        rdata_d = 32'h0000_0000;
        if (cfg_valid_in && !cfg_write_in) begin
            if (hit_cap) begin
                rdata_d[7:0] = cap_ptr;
            end else if (hit_irq) begin
                rdata_d[7:0]   = `BCH_IRQ_LINE_VAL;
                rdata_d[15:8]  = pin_q;
                rdata_d[31:16] = bridge_control_ext_rd;
            end else if (hit_io_high || hit_rom) begin
                rdata_d = 32'h0000_0000;
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // every cycle is acknowledged, writes to fixed bits are dropped
    always @(posedge clk_in) begin
        if (reset_in) begin
            pin_q          <= `BCH_IRQ_PIN_RST;
            pin_locked_out <= 1'b0;
            cfg_ack_out    <= 1'b0;
            cfg_rdata_out  <= 32'h0000_0000;
        end else begin
            pin_q          <= pin_d;
            pin_locked_out <= locked_d;
            cfg_ack_out    <= cfg_valid_in;
            cfg_rdata_out  <= rdata_d;
        end
    end

    // legacy interrupt leaves only as a link message
    bch_intx_msg u_intx_msg (
        .clk_in       (clk_in),
        .reset_in     (reset_in),
        .pin_code_in  (pin_q),
        .irq_level_in (irq_level_in),
        .ready_in     (msg_ready_in),
        .valid_out    (msg_valid_out),
        .assert_out   (msg_assert_out),
        .intx_out     (msg_intx_out)
    );

endmodule // bch_config_tail

// File: verif/bch_config_tail_assertions.sv
// port assertions of the bridge header tail
`timescale 1ns/10ps
module bch_chk (
    input wire        clk_in,         // clock
    input wire        reset_in,       // reset
    input wire        cfg_valid_in,   // request
    input wire        cfg_write_in,   // write
    input wire [7:0]  cfg_addr_in,    // offset
    input wire [3:0]  cfg_be_in,      // lanes
    input wire [8:0]  bridge_control_ext_low_in,   // ctrl low
    input wire        cfg_ack_out,    // ack
    input wire [31:0] cfg_rdata_out,  // rdata
    input wire        pin_locked_out, // locked
    input wire        msg_valid_out,  // msg valid
    input wire        msg_ready_in,   // msg ready
    input wire        msg_assert_out, // msg kind
    input wire [1:0]  msg_intx_out    // msg line
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire       rd = cfg_valid_in & ~cfg_write_in;
    wire [5:0] dw = cfg_addr_in[7:2];
    ack_next_a: assert property (cfg_valid_in |=> cfg_ack_out)
        else $error("ack missing");
    ack_cause_a: assert property (cfg_ack_out |-> $past(cfg_valid_in))
        else $error("ack without request");
    cap_ptr_a: assert property (rd && dw == 6'h0d |=> cfg_rdata_out == 32'h50)
        else $error("capability pointer wrong");
    irq_word_a: assert property (rd && dw == 6'h0f |=> cfg_rdata_out[7:0] == 8'h00 && cfg_rdata_out[31:25] == 7'h00 && cfg_rdata_out[24:16] == $past(bridge_control_ext_low_in))
        else $error("interrupt dword wrong");
    unmapped_zero_a: assert property (rd && (dw == 6'h0c || dw == 6'h0e) |=> cfg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    write_data_a: assert property (cfg_valid_in && cfg_write_in |=> cfg_rdata_out == 32'h0)
        else $error("write returned data");
    lock_hold_a: assert property (pin_locked_out |=> pin_locked_out)
        else $error("lock dropped");
    lock_set_a: assert property (cfg_valid_in && cfg_write_in && dw == 6'h0f && cfg_be_in[1] |=> pin_locked_out)
        else $error("pin write not locked");
    msg_hold_a: assert property (msg_valid_out && !msg_ready_in |=> msg_valid_out && $stable(msg_assert_out) && $stable(msg_intx_out))
        else $error("message not held");
    cover property (rd && dw == 6'h0f ##1 cfg_ack_out);
    cover property (msg_valid_out && msg_ready_in && msg_assert_out);
    cover property (msg_valid_out && !msg_ready_in ##1 msg_ready_in);
endmodule // bch_chk
bind bch_config_tail bch_chk u_chk (.*);

// File: verif/bch_config_tail_tb.sv
// self-checking bench of the bridge header tail
`timescale 1ns/10ps
module bch_config_tail_tb;
    reg          clk_in = 0;
    reg          reset_in = 1;
    reg          cfg_valid_in = 0;
    reg          cfg_write_in = 0;
    reg  [7:0]   cfg_addr_in = 8'h00;
    reg  [3:0]   cfg_be_in = 4'h0;
    reg  [31:0]  cfg_wdata_in = 32'h0;
    reg  [8:0]   bridge_control_ext_low_in = 9'h000;
    reg          irq_level_in = 0;
    reg          msg_ready_in = 0;
    wire         cfg_ack_out, pin_locked_out, msg_valid_out, msg_assert_out;
    wire [31:0]  cfg_rdata_out;
    wire [1:0]   msg_intx_out;
    integer      miscompares = 0, n_checks = 0, i, k;
    logic [31:0] rq[$];
    logic [2:0]  mq[$];
    reg   [7:0]  pin;
    reg          lk;
    always #50 clk_in = ~clk_in;
    always @(negedge clk_in) msg_ready_in <= $urandom;
    bch_config_tail DUT (.*);
    task chk(input [31:0] s, input [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task complete_run;
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task rst;
        reset_in = 1;
        irq_level_in = 0;
        repeat (2) @(negedge clk_in);
        reset_in = 0;
        pin = 8'h01;
        lk = 0;
    endtask
    task cfg(input w, input [7:0] a, input [3:0] be, input [31:0] d);
        {cfg_valid_in, cfg_write_in, cfg_addr_in, cfg_be_in} = {1'b1, w, a, be};
        cfg_wdata_in = d;
        bridge_control_ext_low_in = $urandom;
        rq.push_back(w ? 32'h0 : a[7:2] == 6'h0d ? 32'h50 : a[7:2] == 6'h0f ?
            {7'h00, bridge_control_ext_low_in, pin, 8'h00} : 32'h0);
        if (w && a[7:2] == 6'h0f && be[1] && !lk) begin
            pin = d[15:8];
            lk = 1;
        end
        @(negedge clk_in);
    endtask
    task drain;
        for (k = 0; k < 60 && mq.size() > 0; k++) @(negedge clk_in);
        if (mq.size() > 0) begin
            miscompares++;
            complete_run;
        end
    endtask
    always @(posedge clk_in) begin
        if (cfg_ack_out === 1'b1)
            chk(cfg_rdata_out, rq.size() ? rq.pop_front() : 32'hdead);
        if (msg_valid_out === 1'b1 && msg_ready_in)
            chk({msg_assert_out, msg_intx_out}, mq.size() ? mq.pop_front() : 3'h7);
    end
    initial begin
        void'($urandom(32'h48150f0f));
        rst;
        cfg(0, 8'h3c, 4'hf, 32'h0);
        repeat (40) cfg($urandom, $urandom, $urandom, $urandom);
        cfg(0, 8'h3c, 4'hf, 32'h0);
        cfg_valid_in = 0;
        for (i = 1; i < 6; i++) begin
            rst;
            cfg(1, 8'h3c, 4'h2, i << 8);
            cfg(1, 8'h3c, 4'h2, 32'h0300);
            cfg(0, 8'h3c, 4'hf, 32'h0);
            cfg_valid_in = 0;
            chk(pin_locked_out, 1);
            if (i < 5) mq.push_back({1'b1, i[1:0] - 2'h1});
            irq_level_in = 1;
            drain;
            if (i < 5) mq.push_back({1'b0, i[1:0] - 2'h1});
            irq_level_in = 0;
            drain;
            repeat (20) @(negedge clk_in);
        end
        chk(rq.size(), 0);
        complete_run;
    end
endmodule // bch_config_tail_tb
